// [core/lsl_consts.vh]
// lsl_consts.vh: shared constants of the led sink shift/latch block
// assumes: included by bare name from the fifo and top core files
`ifndef LSL_CONSTS_VH
`define LSL_CONSTS_VH
`define LSL_CHANNELS 16
`define LSL_CHAN_MSB 15
`define LSL_SHIFT_RST 16'h0000
`define LSL_LATCH_RST 16'h0000
`define LSL_SINK_RST 16'h0000
`define LSL_FIFO_DEPTH 16
`define LSL_FIFO_AW 4
// power-on settle time in ns, and the cycles it takes at 100 MHz
`define LSL_SYS_PERIOD_NS 10
`define LSL_POR_NS 100
`define LSL_POR_CYCLES ((`LSL_POR_NS + `LSL_SYS_PERIOD_NS - 1) / `LSL_SYS_PERIOD_NS)
`endif

// [core/lsl_mem.v]
// lsl_mem.v: small dual-port storage with registered read data
// assumes: single clock, one write and one read port per cycle
`timescale 1ns/10ps
module lsl_mem #(
    parameter WIDTH = 1,
    parameter AW = 4
) (
    input wire i_clk,
    input wire i_we,
    input wire [AW-1:0] i_waddr,
    input wire [WIDTH-1:0] i_wdata,
    input wire i_re,
    input wire [AW-1:0] i_raddr,
    output reg [WIDTH-1:0] o_rdata
);
    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    // write port and registered read port
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        if (i_re) begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

// [core/lsl_fifo.v]
// lsl_fifo.v: valid/ready fifo holding sampled serial bits
// assumes: one clock, async active-low reset; read data one cycle late
`timescale 1ns/10ps
`include "lsl_consts.vh"
module lsl_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output reg o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    // depth held at pointer width so the full compare drops no bits
    localparam [AW:0] DEPTH_W = DEPTH;
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    wire [AW:0] count;
    wire full;
    wire empty;
    wire push;
    wire pop;
    wire load;

    assign count = wr_ptr - rd_ptr;
    assign full = (count == DEPTH_W);
    assign empty = (count == {(AW+1){1'b0}});
    assign o_in_ready = ~full;
    assign push = i_in_valid & ~full;
    // output stage refills when empty or being drained
    assign load = ~empty & (~o_out_valid | i_out_ready);
    assign pop = load;

    // pointers and output-stage valid
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
            o_out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
                o_out_valid <= 1'b1;
            end else if (i_out_ready) begin
                o_out_valid <= 1'b0;
            end
        end
    end

    lsl_mem #(.WIDTH(WIDTH), .AW(AW)) u_mem (
        .i_clk(i_clk),
        .i_we(push),
        .i_waddr(wr_ptr[AW-1:0]),
        .i_wdata(i_in_data),
        .i_re(pop),
        .i_raddr(rd_ptr[AW-1:0]),
        .o_rdata(o_out_data)
    );
endmodule

// [core/lsl_top.v]
// lsl_top.v: shift register, level latch and gated sinks of a
// 16-channel led driver, sampled on the 100 MHz system clock
// assumes: serial clock, data, latch and enable come from pins of
// another domain; serial clock stays at or below 25 MHz
`timescale 1ns/10ps
`include "lsl_consts.vh"
module lsl_top (
    input wire I_SYS_CLK,
    input wire I_RST_B,
    input wire I_SERIAL_CLK,
    input wire I_SERIAL_IN,
    input wire I_LATCH_PASS_N,
    input wire I_OUT_EN_N,
    output reg [`LSL_CHAN_MSB:0] O_CHANNEL_SINK,
    output reg O_SERIAL_OUT,
    output reg O_FIFO_FULL
);
    // pin synchronisers, two stages each
    reg sck_s1;
    reg sck_s2;
    reg sck_d;
    reg sin_s1;
    reg sin_s2;
    reg lat_s1;
    reg lat_s2;
    reg oe_s1;
    reg oe_s2;
    // power-on hold counter
    reg [3:0] por_cnt;
    reg por_done;
    // core state
    reg [`LSL_CHAN_MSB:0] shift_reg;
    reg [`LSL_CHAN_MSB:0] latch_reg;
    wire sck_rise;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_bit;
    wire shift_take;
    wire [`LSL_CHAN_MSB:0] next_shift;
    wire [`LSL_CHAN_MSB:0] next_latch;
    wire [`LSL_CHAN_MSB:0] next_sink;

    // two-flop synchronisers for every pin input
    always @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_d <= 1'b0;
            sin_s1 <= 1'b0;
            sin_s2 <= 1'b0;
            lat_s1 <= 1'b0;
            lat_s2 <= 1'b0;
            oe_s1 <= 1'b1;
            oe_s2 <= 1'b1;
        end else begin
            sck_s1 <= I_SERIAL_CLK;
            sck_s2 <= sck_s1;
            sck_d <= sck_s2;
            sin_s1 <= I_SERIAL_IN;
            sin_s2 <= sin_s1;
            lat_s1 <= I_LATCH_PASS_N;
            lat_s2 <= lat_s1;
            oe_s1 <= I_OUT_EN_N;
            oe_s2 <= oe_s1;
        end
    end

    // rising edge of the serial clock, found on synchronised copies
    assign sck_rise = sck_s2 & ~sck_d;

    // power-on hold: state kept cleared until the settle time has passed
    always @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            por_cnt <= 4'h0;
            por_done <= 1'b0;
        end else if (!por_done) begin
            if (por_cnt == (`LSL_POR_CYCLES - 1)) begin
                por_done <= 1'b1;
            end
            por_cnt <= por_cnt + 4'h1;
        end
    end

    // sampled serial bits queue here; the shifter drains one per cycle
    lsl_fifo #(
        .WIDTH(1),
        .DEPTH(`LSL_FIFO_DEPTH),
        .AW(`LSL_FIFO_AW)
    ) u_fifo (
        .i_clk(I_SYS_CLK),
        .i_rst_b(I_RST_B),
        .i_in_valid(sck_rise & por_done),
        .o_in_ready(fifo_in_ready),
        .i_in_data(sin_s2),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(por_done),
        .o_out_data(fifo_out_bit)
    );

    assign shift_take = fifo_out_valid & por_done;

    // newest bit at stage zero, older bits move toward stage fifteen
    assign next_shift = shift_take ?
        {shift_reg[`LSL_CHAN_MSB-1:0], fifo_out_bit} : shift_reg;

    // level latch: open while latch control high, else hold
    assign next_latch = lat_s2 ? next_shift : latch_reg;

    // sinks on for ones, all forced off while enable is high
    assign next_sink = oe_s2 ? `LSL_SINK_RST : next_latch;

    // shift register, latch and outputs
    always @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            shift_reg <= `LSL_SHIFT_RST;
            latch_reg <= `LSL_LATCH_RST;
            O_CHANNEL_SINK <= `LSL_SINK_RST;
            O_SERIAL_OUT <= 1'b0;
            O_FIFO_FULL <= 1'b0;
        end else begin
            shift_reg <= next_shift;
            latch_reg <= next_latch;
            O_CHANNEL_SINK <= next_sink;
            O_SERIAL_OUT <= next_shift[`LSL_CHAN_MSB];
            O_FIFO_FULL <= ~fifo_in_ready;
        end
    end
endmodule

// [verification/lsl_top_monitor.sv]
// lsl_top_monitor.sv: port checker of the led sink shift/latch top
// assumes: bound to lsl_top, sees only its ports
`timescale 1ns/10ps
module lsl_mon (
    input wire I_SYS_CLK,
    input wire I_RST_B,
    input wire I_SERIAL_CLK,
    input wire I_SERIAL_IN,
    input wire I_LATCH_PASS_N,
    input wire I_OUT_EN_N,
    input wire [15:0] O_CHANNEL_SINK,
    input wire O_SERIAL_OUT,
    input wire O_FIFO_FULL
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_B);
    // outputs, shift and latch relations
    rst_clear_a: assert property ($rose(I_RST_B) |->
        O_CHANNEL_SINK == 16'h0000 && !O_SERIAL_OUT) else $error("not clear");
    en_off_a: assert property (I_OUT_EN_N[*5] |->
        O_CHANNEL_SINK == 16'h0000) else $error("sinks on while disabled");
    sink_gate_a: assert property (O_CHANNEL_SINK != 16'h0000 |->
        !$past(I_OUT_EN_N, 3)) else $error("sink on without enable");
    serial_out_cause_a: assert property ($changed(O_SERIAL_OUT) |->
        $past(I_SERIAL_CLK, 5) || $past(I_SERIAL_CLK, 6))
        else $error("serial out moved without clock");
    latch_hold_a: assert property ((!I_LATCH_PASS_N && !I_OUT_EN_N)[*6] |->
        $stable(O_CHANNEL_SINK)) else $error("closed latch changed");
    pass_thru_a: assert property ((I_LATCH_PASS_N && !I_OUT_EN_N)[*8] |->
        O_CHANNEL_SINK[15] == O_SERIAL_OUT) else $error("open latch differs");
    shift_on_a: assert property ((I_LATCH_PASS_N && !I_OUT_EN_N)[*8] ##0
        $changed(O_CHANNEL_SINK) |->
        O_CHANNEL_SINK[15:1] == $past(O_CHANNEL_SINK[14:0]))
        else $error("sinks did not shift");
    fifo_quiet_a: assert property (!O_FIFO_FULL) else $error("bits lost");
endmodule
bind lsl_top lsl_mon mon (.I_SYS_CLK, .I_RST_B, .I_SERIAL_CLK, .I_SERIAL_IN,
    .I_LATCH_PASS_N, .I_OUT_EN_N, .O_CHANNEL_SINK, .O_SERIAL_OUT,
    .O_FIFO_FULL);

// [verification/lsl_ctrl_model.sv]
// lsl_ctrl_model.sv: display controller sending 16-bit frames
// assumes: driven off the falling system clock edge
`timescale 1ns/10ps
module lsl_ctrl_model (
    input wire clk,
    input wire start,
    input wire [15:0] word,
    output reg sck,
    output reg sdi,
    output wire busy
);
    reg [15:0] sh = 16'h0000;
    reg [4:0] n = 5'h00;
    reg [3:0] ph = 4'h0;
    initial sck = 1'b0;
    initial sdi = 1'b0;
    assign busy = (n != 5'h00);
    // 160 ns serial period, clock still and data toggling between frames
    always @(negedge clk) begin
        if (n == 5'h00) begin
            sck <= 1'b0;
            sdi <= ~sdi;
            ph <= 4'h0;
            if (start) begin
                sh <= word;
                n <= 5'h10;
            end
        end else begin
            ph <= ph + 4'h1;
            if (ph == 4'h0) sdi <= sh[15];
            if (ph == 4'h4) sck <= 1'b1;
            if (ph == 4'hC) begin
                sck <= 1'b0;
                sh <= sh << 1;
                n <= n - 5'h01;
            end
        end
    end
endmodule

// [verification/tb_led_driver_shift_latch.sv]
// tb_led_driver_shift_latch.sv: self-checking bench of lsl_top
// assumes: the controller model drives the serial pins
`timescale 1ns/10ps
module tb_led_driver_shift_latch;
    reg clk = 0, rst_b = 0, start = 0, latch_pass_n = 1, en_n = 0;
    reg [15:0] word = 16'h0000, held, nw;
    reg [31:0] seed = 32'd53686;
    wire sck, sdi, busy, serial_out, full;
    wire [15:0] sink;
    integer n_mismatch = 0, samples_checked = 0, i;
    lsl_top dut (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_SERIAL_CLK(sck),
        .I_SERIAL_IN(sdi), .I_LATCH_PASS_N(latch_pass_n), .I_OUT_EN_N(en_n),
        .O_CHANNEL_SINK(sink), .O_SERIAL_OUT(serial_out), .O_FIFO_FULL(full));
    lsl_ctrl_model ctl (.clk(clk), .start(start), .word(word), .sck(sck),
        .sdi(sdi), .busy(busy));
    initial forever #5 clk = ~clk;
    // xorshift source of frame words
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task chk(input [31:0] nm, input [15:0] e, input [15:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wt;
        repeat (8) @(negedge clk);
    endtask
    // one frame, then let the outputs settle
    task send(input [15:0] w);
        integer k;
        begin
            word <= w;
            @(negedge clk) start <= 1'b1;
            @(negedge clk) start <= 1'b0;
            repeat (2) @(negedge clk);
            for (k = 0; busy && k < 400; k = k + 1) @(negedge clk);
            wt;
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
            if (n_mismatch == 0 && samples_checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // main sequence
    initial begin
        repeat (2) @(negedge clk);
        rst_b <= 1'b1;
        @(negedge clk) chk("rst", 16'h0000, sink);
        chk("rst", 16'h0000, {15'h0000, serial_out});
        repeat (12) @(negedge clk);
        for (i = 0; i < 6; i = i + 1) begin
            seed = xs(seed);
            held = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0001 : seed[15:0];
            send(held);
            chk("sink", held, sink);
            chk("serial_out", {15'h0000, held[15]}, {15'h0000, serial_out});
            chk("full", 16'h0000, {15'h0000, full});
        end
        $display("test frames done");
        @(negedge clk) latch_pass_n <= 1'b0;
        wt;
        seed = xs(seed);
        nw = seed[15:0];
        send(nw);
        chk("hold", held, sink);
        @(negedge clk) latch_pass_n <= 1'b1;
        wt;
        chk("pass", nw, sink);
        $display("test latch done");
        @(negedge clk) en_n <= 1'b1;
        send(~nw);
        chk("off", 16'h0000, sink);
        chk("serial_out", {15'h0000, ~nw[15]}, {15'h0000, serial_out});
        @(negedge clk) en_n <= 1'b0;
        wt;
        chk("on", ~nw, sink);
        $display("test enable done");
        finish_test;
    end
    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        finish_test;
    end
endmodule
